// [pkg/ilr_consts.vh]
`ifndef ILR_CONSTS_VH
`define ILR_CONSTS_VH

`define ILR_BYTE_W        8
`define ILR_PAGE_W        16
`define ILR_PAGE_LSB      40
`define ILR_CW_W          64
`define ILR_CW_CALRST_BIT 56
`define ILR_NUM_CH        2

// release spacing of the reset sequence, in clk cycles
`define ILR_XCVR_HOLD_CYC 16'h0040
`define ILR_PCS_HOLD_CYC  16'h0020
`define ILR_MAC_HOLD_CYC  16'h0010
`define ILR_CNT_W         16

`endif

// [rtl/ilr_rx_app.v]
`include "ilr_consts.vh"

module ilr_rx_app #(
   parameter DATA_W     = 128,
   parameter EMPTY_W    = (DATA_W == 512) ? 6 : (DATA_W == 256) ? 5 : 4,
   parameter CAL_PAGES  = 1,
   parameter EXPOSE_CAL = 1,
   parameter CAL_W      = 16 * CAL_PAGES,
   parameter XCVR_HOLD  = `ILR_XCVR_HOLD_CYC,
   parameter PCS_HOLD   = `ILR_PCS_HOLD_CYC,
   parameter MAC_HOLD   = `ILR_MAC_HOLD_CYC
) (
   input  wire               clk,          // receive MAC clock
   input  wire               rst,          // global reset, async, high
   // reset controller outputs towards the core blocks
   output wire               xcvr_rst,     // transceiver reset
   output wire               pcs_rx_rst,   // receive PCS reset
   output wire               pcs_tx_rst,   // transmit PCS reset
   output wire               mac_rx_rst,   // receive MAC reset
   output wire               mac_tx_rst,   // transmit MAC reset
   output wire               txfifo_rst,   // transmit FIFO reset
   output wire               core_ready,   // sequence complete
   // words from the packet regrouper
   input  wire               rg_valid,     // word present
   input  wire               rg_chan,      // destination channel
   input  wire [DATA_W-1:0]  rg_data,      // word data
   input  wire               rg_sop,       // word starts a packet
   input  wire               rg_eop,       // word ends a packet
   input  wire               rg_err,       // packet fault, with eop
   input  wire [EMPTY_W-1:0] rg_empty,     // unused bytes, with eop
   // link control words
   input  wire               cw_valid,     // control word present
   input  wire [63:0]        cw_word,      // control word
   // channel 0
   output wire [DATA_W-1:0]  ch0_data,     // data
   output wire               ch0_valid,    // data valid
   output wire               ch0_sop,      // start of packet
   output wire               ch0_eop,      // end of packet
   output wire               ch0_error,    // packet error
   output wire [EMPTY_W-1:0] ch0_empty,    // unused byte count
   // channel 1
   output wire [DATA_W-1:0]  ch1_data,     // data
   output wire               ch1_valid,    // data valid
   output wire               ch1_sop,      // start of packet
   output wire               ch1_eop,      // end of packet
   output wire               ch1_error,    // packet error
   output wire [EMPTY_W-1:0] ch1_empty,    // unused byte count
   // flow control calendar
   output wire [CAL_W-1:0]   cal_pages     // calendar bits
);

   localparam [2:0] S_HOLD = 3'h0;
   localparam [2:0] S_XCVR = 3'h1;
   localparam [2:0] S_PCS  = 3'h2;
   localparam [2:0] S_MAC  = 3'h3;
   localparam [2:0] S_RUN  = 3'h4;
   localparam       CW     = `ILR_CNT_W;
   localparam       PIX_W  = 5;

   // ---------------- reset controller ----------------
   // assert asynchronously, release through two flops so that any
   // release edge of the global reset is safe
   reg        rs1_q;
   reg        rs2_q;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rs1_q <= 1'b1;
         rs2_q <= 1'b1;
      end else begin
         rs1_q <= 1'b0;
         rs2_q <= rs1_q;
      end
   end

   // the sequence never starts while the synchronised reset is high,
   // so a short pulse still restarts it from the beginning
   reg [2:0]    st_q;
   reg [2:0]    st_d;
   reg [CW-1:0] cnt_q;
   reg [CW-1:0] cnt_d;
   reg          xcvr_q;
   reg          pcs_q;
   reg          mac_q;

   always @* begin
      st_d  = st_q;
      cnt_d = cnt_q + 1'b1;
      case (st_q)
         S_HOLD: begin
            cnt_d = {CW{1'b0}};
            st_d  = S_XCVR;
         end
         S_XCVR: begin
            if (cnt_q == XCVR_HOLD[CW-1:0] - 1'b1) begin
               cnt_d = {CW{1'b0}};
               st_d  = S_PCS;
            end
         end
         S_PCS: begin
            if (cnt_q == PCS_HOLD[CW-1:0] - 1'b1) begin
               cnt_d = {CW{1'b0}};
               st_d  = S_MAC;
            end
         end
         S_MAC: begin
            if (cnt_q == MAC_HOLD[CW-1:0] - 1'b1) begin
               cnt_d = {CW{1'b0}};
               st_d  = S_RUN;
            end
         end
         S_RUN: begin
            cnt_d = cnt_q;
         end
         default: begin
            cnt_d = {CW{1'b0}};
            st_d  = S_HOLD;
         end
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q   <= S_HOLD;
         cnt_q  <= {CW{1'b0}};
         xcvr_q <= 1'b1;
         pcs_q  <= 1'b1;
         mac_q  <= 1'b1;
      end else if (rs2_q) begin
         st_q   <= S_HOLD;
         cnt_q  <= {CW{1'b0}};
         xcvr_q <= 1'b1;
         pcs_q  <= 1'b1;
         mac_q  <= 1'b1;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         // transceivers first, then PCS, then MACs and FIFO
         xcvr_q <= (st_d == S_HOLD);
         pcs_q  <= (st_d == S_HOLD) || (st_d == S_XCVR);
         mac_q  <= (st_d != S_RUN);
      end
   end

   // three staged resets reach the core blocks; rx and tx share one per layer, the FIFO shares the MAC one
   assign xcvr_rst   = xcvr_q;
   assign pcs_rx_rst = pcs_q;
   assign pcs_tx_rst = pcs_q;
   assign mac_rx_rst = mac_q;
   assign mac_tx_rst = mac_q;
   assign txfifo_rst = mac_q;
   assign core_ready = ~mac_q;

   // ---------------- receive channels ----------------
   wire [`ILR_NUM_CH*DATA_W-1:0]  dat_v;
   wire [`ILR_NUM_CH-1:0]         val_v;
   wire [`ILR_NUM_CH-1:0]         sop_v;
   wire [`ILR_NUM_CH-1:0]         eop_v;
   wire [`ILR_NUM_CH-1:0]         err_v;
   wire [`ILR_NUM_CH*EMPTY_W-1:0] emp_v;

   genvar g;
   generate
      for (g = 0; g < `ILR_NUM_CH; g = g + 1) begin : g_ch
         reg [DATA_W-1:0]  d_q;
         reg               v_q;
         reg               s_q;
         reg               e_q;
         reg               er_q;
         reg [EMPTY_W-1:0] m_q;
         reg               pkt_q;
         wire              hit;
         wire              take;

         assign hit  = rg_valid && (rg_chan == g);
         // a word outside a packet that does not open one is dropped,
         // so a consumer never sees a headless fragment
         assign take = hit && (rg_sop || pkt_q);

         always @(posedge clk or posedge rst) begin
            if (rst) begin
               d_q   <= {DATA_W{1'b0}};
               v_q   <= 1'b0;
               s_q   <= 1'b0;
               e_q   <= 1'b0;
               er_q  <= 1'b0;
               m_q   <= {EMPTY_W{1'b0}};
               pkt_q <= 1'b0;
            end else if (mac_q) begin
               v_q   <= 1'b0;
               s_q   <= 1'b0;
               e_q   <= 1'b0;
               er_q  <= 1'b0;
               m_q   <= {EMPTY_W{1'b0}};
               pkt_q <= 1'b0;
            end else begin
               v_q  <= take;
               s_q  <= take && rg_sop;
               e_q  <= take && rg_eop;
               er_q <= take && rg_eop && rg_err;
               if (take) begin
                  d_q   <= rg_data;
                  pkt_q <= ~rg_eop;
               end
               // count of unused low bytes, kept only on the last word
               if (take && rg_eop) begin
                  m_q <= rg_empty;
               end else begin
                  m_q <= {EMPTY_W{1'b0}};
               end
            end
         end

         assign dat_v[g*DATA_W +: DATA_W]   = d_q;
         assign val_v[g]                    = v_q;
         assign sop_v[g]                    = s_q;
         assign eop_v[g]                    = e_q;
         assign err_v[g]                    = er_q;
         assign emp_v[g*EMPTY_W +: EMPTY_W] = m_q;
      end
   endgenerate

   assign ch0_data  = dat_v[0 +: DATA_W];
   assign ch1_data  = dat_v[DATA_W +: DATA_W];
   assign ch0_valid = val_v[0];
   assign ch1_valid = val_v[1];
   assign ch0_sop   = sop_v[0];
   assign ch1_sop   = sop_v[1];
   assign ch0_eop   = eop_v[0];
   assign ch1_eop   = eop_v[1];
   assign ch0_error = err_v[0];
   assign ch1_error = err_v[1];
   assign ch0_empty = emp_v[0 +: EMPTY_W];
   assign ch1_empty = emp_v[EMPTY_W +: EMPTY_W];

   // ---------------- calendar ----------------
   // pages fill in arrival order; the calendar-restart bit of a control
   // word puts its page back at index 0
   generate
      if (EXPOSE_CAL != 0) begin : g_cal
         reg  [PIX_W-1:0] pix_q;
         reg  [CAL_W-1:0] cal_q;
         wire [PIX_W-1:0] wix;
         assign wix = cw_word[`ILR_CW_CALRST_BIT] ? {PIX_W{1'b0}} : pix_q;

         always @(posedge clk or posedge rst) begin
            if (rst) begin
               pix_q <= {PIX_W{1'b0}};
               cal_q <= {CAL_W{1'b0}};
            end else if (mac_q) begin
               pix_q <= {PIX_W{1'b0}};
               cal_q <= {CAL_W{1'b0}};
            end else if (cw_valid) begin
               cal_q[wix*`ILR_PAGE_W +: `ILR_PAGE_W] <=
                  cw_word[`ILR_PAGE_LSB +: `ILR_PAGE_W];
               if (wix == CAL_PAGES[PIX_W-1:0] - 1'b1) begin
                  pix_q <= {PIX_W{1'b0}};
               end else begin
                  pix_q <= wix + 1'b1;
               end
            end
         end
         assign cal_pages = cal_q;
      end else begin : g_nocal
         assign cal_pages = {CAL_W{1'b0}};
      end
   endgenerate

endmodule // ilr_rx_app

// [tb/ilr_rx_app_chk.sv]
module ilr_rx_app_chk #(
   parameter int EMPTY_W   = 4,
   parameter int CAL_W     = 16,
   parameter int XCVR_HOLD = 64,
   parameter int PCS_HOLD  = 32,
   parameter int MAC_HOLD  = 16
) (
   input wire logic               clk,        // clock
   input wire logic               rst,        // reset
   input wire logic               xcvr_rst,   // xcvr reset
   input wire logic               pcs_rx_rst, // pcs reset
   input wire logic               mac_rx_rst, // mac reset
   input wire logic               txfifo_rst, // fifo reset
   input wire logic               core_ready, // ready
   input wire logic               rg_valid,   // word in
   input wire logic               rg_chan,    // channel
   input wire logic               rg_sop,     // sop in
   input wire logic               rg_eop,     // eop in
   input wire logic               rg_err,     // error in
   input wire logic [EMPTY_W-1:0] rg_empty,   // empty in
   input wire logic               cw_valid,   // ctrl word
   input wire logic [63:0]        cw_word,    // ctrl data
   input wire logic               ch0_valid,  // ch0 valid
   input wire logic               ch0_sop,    // ch0 sop
   input wire logic               ch0_eop,    // ch0 eop
   input wire logic               ch0_error,  // ch0 error
   input wire logic               ch1_valid,  // ch1 valid
   input wire logic               ch1_eop,    // ch1 eop
   input wire logic               ch1_error,  // ch1 error
   input wire logic [EMPTY_W-1:0] ch1_empty,  // ch1 empty
   input wire logic [CAL_W-1:0]   cal_pages   // calendar
);
   // mac and fifo leave reset once both later hold spans have run out
   localparam int PM_HOLD = PCS_HOLD + MAC_HOLD;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   rst_outs_a: assert property (disable iff (1'b0) rst |-> xcvr_rst &&
      pcs_rx_rst && mac_rx_rst && txfifo_rst && !core_ready && !ch0_valid)
      else $error("outputs not held by reset");
   xcvr_pcs_a: assert property ($fell(xcvr_rst) |-> ##XCVR_HOLD $fell(pcs_rx_rst))
      else $error("pcs release spacing wrong");
   pcs_mac_a: assert property ($fell(pcs_rx_rst) |-> ##PM_HOLD $fell(mac_rx_rst))
      else $error("mac release spacing wrong");
   mac_ready_a: assert property ($fell(mac_rx_rst) |-> $rose(core_ready))
      else $error("ready spacing wrong");
   ready_gate_a: assert property (!core_ready |=> !ch0_valid && !ch1_valid)
      else $error("output while not ready");
   ch0_sop_a: assert property (core_ready && rg_valid && !rg_chan && rg_sop
      |=> ch0_valid && ch0_sop && !ch1_valid) else $error("ch0 start lost");
   ch1_eop_a: assert property (core_ready && rg_valid && rg_chan && rg_sop &&
      rg_eop |=> ch1_valid && ch1_eop && ch1_error == $past(rg_err) &&
      ch1_empty == $past(rg_empty)) else $error("ch1 end qualifiers wrong");
   err_eop_a: assert property (ch0_error |-> ch0_eop && ch0_valid)
      else $error("error outside end word");
   cal_page_a: assert property (core_ready && cw_valid && cw_word[56] |=>
      cal_pages[15:0] == $past(cw_word[55:40])) else $error("page wrong");
endmodule // ilr_rx_app_chk

bind ilr_rx_app ilr_rx_app_chk #(.EMPTY_W(EMPTY_W), .CAL_W(CAL_W),
   .XCVR_HOLD(XCVR_HOLD), .PCS_HOLD(PCS_HOLD), .MAC_HOLD(MAC_HOLD)) u_chk (
   .clk(clk), .rst(rst), .xcvr_rst(xcvr_rst), .pcs_rx_rst(pcs_rx_rst),
   .mac_rx_rst(mac_rx_rst), .txfifo_rst(txfifo_rst),
   .core_ready(core_ready), .rg_valid(rg_valid), .rg_chan(rg_chan),
   .rg_sop(rg_sop), .rg_eop(rg_eop), .rg_err(rg_err), .rg_empty(rg_empty),
   .cw_valid(cw_valid), .cw_word(cw_word), .ch0_valid(ch0_valid),
   .ch0_sop(ch0_sop), .ch0_eop(ch0_eop), .ch0_error(ch0_error),
   .ch1_valid(ch1_valid), .ch1_eop(ch1_eop), .ch1_error(ch1_error),
   .ch1_empty(ch1_empty), .cal_pages(cal_pages));

// [tb/ilr_rx_app_tb.sv]
module ilr_rx_app_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int H = 4;
   logic clk = 0, rst = 0, rv = 0, rc = 0, rs = 0, re = 0, rer = 0, cv = 0;
   logic [127:0] rd = 128'h0;
   logic [3:0] rm = 4'h0;
   logic [63:0] cw = 64'h0;
   wire [127:0] d0, d1;
   wire v0, s0, e0, r0, v1, s1, e1, r1, xr, pr, pt, mr, mt, fr, rdy;
   wire [3:0] m0, m1;
   wire [31:0] cal;
   wire [15:0] pk, pe;
   int errors = 0, cmp_count = 0, np = 0, ne = 0, ci = 0, n;
   logic [31:0] x = 32'hEAC1, r, ecal;
   logic ok = 0, on = 0;
   logic ip [2];
   logic [135:0] ex [2];
   logic [127:0] ld [2];
   always #20 clk = ~clk;
   ilr_rx_app #(.DATA_W(128), .CAL_PAGES(2), .XCVR_HOLD(H), .PCS_HOLD(H),
      .MAC_HOLD(H)) DUT (.clk(clk), .rst(rst), .xcvr_rst(xr),
      .pcs_rx_rst(pr), .pcs_tx_rst(pt), .mac_rx_rst(mr), .mac_tx_rst(mt),
      .txfifo_rst(fr), .core_ready(rdy), .rg_valid(rv), .rg_chan(rc),
      .rg_data(rd), .rg_sop(rs), .rg_eop(re), .rg_err(rer), .rg_empty(rm),
      .cw_valid(cv), .cw_word(cw), .ch0_data(d0), .ch0_valid(v0),
      .ch0_sop(s0), .ch0_eop(e0), .ch0_error(r0), .ch0_empty(m0),
      .ch1_data(d1), .ch1_valid(v1), .ch1_sop(s1), .ch1_eop(e1),
      .ch1_error(r1), .ch1_empty(m1), .cal_pages(cal));
   ilr_sink u_sink (.clk(clk), .rst(rst), .ch0_valid(v0), .ch0_eop(e0),
      .ch0_error(r0), .ch1_valid(v1), .ch1_eop(e1), .ch1_error(r1),
      .pkt_q(pk), .err_q(pe));
   function logic [31:0] xs();
      x ^= x << 13; x ^= x >> 17; x ^= x << 5;
      return x;
   endfunction
   task chk(string nm, logic [135:0] e, logic [135:0] o);
      cmp_count++;
      if (o !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, o);
      end
   endtask
   task summarize();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task step(logic v, c, s, eo, er, logic [3:0] em, logic w, logic [63:0] k);
      logic [127:0] dat;
      dat = {xs(), xs(), xs(), xs()};
      @(posedge clk);
      {rv, rc, rs, re, rer, rm, cv, cw, rd} <= {v, c, s, eo, er, em, w, k, dat};
      @(negedge clk);
      if (on) begin
         chk("ch0", ex[0], {v0, s0, e0, r0, m0, d0});
         chk("ch1", ex[1], {v1, s1, e1, r1, m1, d1});
         chk("cal", {104'h0, ecal}, {104'h0, cal});
      end
      for (int i = 0; i < 2; i++) ex[i] = {8'h0, ld[i]};
      // a word with no start outside a packet is dropped
      if (ok && v && (s || ip[c])) begin
         ld[c] = dat;
         ip[c] = !eo;
         ex[c] = {1'b1, s, eo, er & eo, eo ? em : 4'h0, dat};
         np += eo;
         ne += er & eo;
      end
      if (ok && w) begin
         if (k[56]) ci = 0;
         ecal[16*ci+:16] = k[55:40];
         ci = (ci + 1) % 2;
      end
   endtask
   task reset_seq();
      on = 0;
      ok = 0;
      // a real rising edge on rst, off any clock edge on purpose
      #13 rst = 1;
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk("reset", {7'h7E, 34'h0}, {xr, pr, pt, mr, mt, fr, rdy, v0, v1, cal});
      @(posedge clk) rst <= 1'b0;
      {ip[0], ip[1], ecal, ci, np, ne, ld[0], ld[1]} = '0;
      ex[0] = 136'h0;
      ex[1] = 136'h0;
      on = 1;
      n = 0;
      // traffic while held in reset must be ignored
      while (xr !== 1'b0 && n < 10) begin
         step(1, n[0], 1, 1, 1, 4'h5, 1, {32'h01FFFF00, xs()});
         n++;
      end
      n = 0;
      while (rdy !== 1'b1 && n < 100) begin
         // the word driven in the cycle where ready rises would be taken,
         // so that one is left idle
         step(n != 3 * H - 1, 1, 1, 0, 0, 4'h0, n != 3 * H - 1, {xs(), xs()});
         n++;
      end
      chk("ready_delay", 136'(3 * H), 136'(n));
      ok = 1;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      summarize();
   end
   initial begin
      reset_seq();
      step(1, 0, 0, 1, 1, 4'hF, 0, 64'h0);
      step(1, 1, 1, 1, 1, 4'h1, 1, 64'h00FFABCD00000000);
      step(1, 1, 1, 0, 0, 4'h0, 1, 64'h0000123400000000);
      step(1, 1, 1, 0, 0, 4'h0, 0, 64'h0);
      step(1, 1, 0, 1, 0, 4'h2, 1, 64'h0100567800000000);
      for (int j = 0; j < 600; j++) begin
         r = xs();
         step(r[0] | r[1], r[2], r[3] & r[4], r[5] & r[6], r[7], r[11:8],
              r[12] & r[13], {xs(), xs()});
         if (j == 300) begin
            step(1, 0, 1, 0, 0, 4'h0, 0, 64'h0);
            reset_seq();
         end
      end
      // two idle words so the sink has counted the last packet end
      repeat (2) step(0, 0, 0, 0, 0, 4'h0, 0, 64'h0);
      chk("packets", 136'(np), 136'(pk));
      chk("bad_packets", 136'(ne), 136'(pe));
      summarize();
   end
endmodule // ilr_rx_app_tb

// [tb/ilr_sink.sv]
module ilr_sink (
   input  wire logic        clk,       // clock
   input  wire logic        rst,       // reset
   input  wire logic        ch0_valid, // ch0 valid
   input  wire logic        ch0_eop,   // ch0 eop
   input  wire logic        ch0_error, // ch0 error
   input  wire logic        ch1_valid, // ch1 valid
   input  wire logic        ch1_eop,   // ch1 eop
   input  wire logic        ch1_error, // ch1 error
   output logic      [15:0] pkt_q,     // packets seen
   output logic      [15:0] err_q      // bad packets
);
   // error is only trusted on a valid end word
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pkt_q <= 16'h0;
         err_q <= 16'h0;
      end else begin
         pkt_q <= pkt_q + 16'(ch0_valid & ch0_eop) + 16'(ch1_valid & ch1_eop);
         err_q <= err_q + 16'(ch0_valid & ch0_eop & ch0_error)
                        + 16'(ch1_valid & ch1_eop & ch1_error);
      end
   end
endmodule // ilr_sink
